// ==== rtl/sim_integrity_monitor.sv ====
// System integrity monitor: reset sequencing, supply warning, clock guard.
//
// What this block does
// - Hold reset while supply below hysteresis threshold.
// - Drive shared reset pin low during low-voltage reset.
// - Watchdog underflow drives reset pin for minimum width.
// - Low-voltage reset exists only when option selects it.
// - Supply warning flag readable, read-only, real time.
// - Supply warning works only with low-voltage option.
// - Enabled warning interrupt on every flag toggle.
// - No warning interrupt for crossing inside reset delay.
// - Slow rise, early enable: two interrupts.
// - Slow rise, late enable: exactly one interrupt.
// - Lost oscillator: keep clocking from backup PLL.
// - Backup PLL enabled by option or software, doubles.
// - No clock at start-up keeps device in reset.
// - Backup selection sets guard flag, interrupt if enabled.
// - In WAIT both interrupts wake the device.
// - HALT disables clock guard; reset restores defaults.
// - Supply warning stays active and wakes from HALT.
// - Interrupts need own enable and cleared global mask.
// - Guard interrupt wakes active-halt, not full HALT.
// - Bit 7 selects register page.
// - Bit 6 enables supply warning interrupt.
// - Warning pending clears on entering its service routine.
// - Bit 5 is the read-only supply warning flag.
// - Guard flag cleared by read after recovery; PLL-off zero.
// - Guard interrupt enable ignored while PLL disabled.
// - Watchdog flag set by watchdog, cleared by write/lowvolt.
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module sim_integrity_monitor (
  input wire logic sys_clk,
  input wire logic rstn,
  // Avalon-MM slave.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Device side.
  input wire sim_pkg::sim_opt_t opt,
  input wire sim_pkg::sim_supply_t supply,
  input wire sim_pkg::sim_cpu_t cpu,
  input wire logic oscPresent,
  input wire logic wdgUnderflow,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  output logic cpuReset,
  output logic clockFromBackup,
  output logic backupPllRun,
  output logic warnIrq,
  output logic guardIrq,
  output logic wakeUp
);

  sim_pkg::sim_rst_state_t rstState;
  sim_pkg::sim_rst_state_t next_rstState;
  logic lvdHold;
  logic delayDone;
  logic pulseDone;
  logic [12:0] delayLen;
  logic ack;
  logic acceptRd;
  logic acceptWr;
  logic ctrlWr;
  logic pllWr;
  logic page;
  logic warnIe;
  logic guardIe;
  logic backup_pll_enable;
  logic lvRf;
  logic watchdog_reset_flag;
  logic warnFlag;
  logic warnPrev;
  logic warnPend;
  logic warnSet;
  logic guardDet;
  logic guardPend;
  logic onBackupPrev;
  logic pllOn;
  logic onBackup;
  logic running;
  logic [7:0] ctrlView;
  logic [31:0] next_readdata;

  // ---------------- Reset sequencer ----------------

  // Hysteresis: a running device only drops on the lower threshold, a
  // device in reset waits for the upper one.
  assign lvdHold = opt.lowVoltEn &&
    ((rstState == sim_pkg::SIM_RUN) ? supply.belowFall
                                    : supply.belowRise);

  assign delayLen = opt.longDelay ? sim_pkg::RST_DELAY_LONG_CYC
                                  : sim_pkg::RST_DELAY_SHORT_CYC;

  sim_down_timer #(
    .W(sim_pkg::TIMER_W)
  ) u_delay (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(rstState != sim_pkg::SIM_DELAY),
    .loadValue(delayLen),
    .run(oscPresent),
    .done(delayDone)
  );

  sim_down_timer #(
    .W(sim_pkg::TIMER_W)
  ) u_pulse (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(rstState != sim_pkg::SIM_WDG),
    .loadValue(sim_pkg::WDG_PULSE_CYC),
    .run(1'b1),
    .done(pulseDone)
  );

  always_comb
  begin
    next_rstState = rstState;
    if (lvdHold)
      next_rstState = sim_pkg::SIM_ACTIVE;
    else
    begin
      case (rstState)
        sim_pkg::SIM_ACTIVE:
          next_rstState = sim_pkg::SIM_DELAY;
        sim_pkg::SIM_DELAY:
          // The delay only counts with a live oscillator.
          if (delayDone && oscPresent)
            next_rstState = sim_pkg::SIM_RUN;
        sim_pkg::SIM_WDG:
          if (pulseDone)
            next_rstState = sim_pkg::SIM_DELAY;
        sim_pkg::SIM_RUN:
          if (wdgUnderflow)
            next_rstState = sim_pkg::SIM_WDG;
          else if (!resetPinIn)
            next_rstState = sim_pkg::SIM_ACTIVE;
        default:
          next_rstState = sim_pkg::SIM_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rstState <= sim_pkg::SIM_ACTIVE;
    else
      rstState <= next_rstState;
  end

  assign running = (rstState == sim_pkg::SIM_RUN);
  assign cpuReset = !running;
  // The pin stays low through every phase but run, so all devices on the
  // shared line see the whole reset.
  assign resetPinOe = !running;
  assign resetPinOut = 1'b0;

  // Reset cause flags survive the device reset they record.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lvRf <= 1'b0;
      watchdog_reset_flag <= 1'b0;
    end
    else
    begin
      if (ctrlWr && !writedata[sim_pkg::BIT_LV_RF])
        lvRf <= 1'b0;
      if (ctrlWr && !writedata[sim_pkg::BIT_WDG_RF])
        watchdog_reset_flag <= 1'b0;
      if (lvdHold)
      begin
        lvRf <= 1'b1;
        watchdog_reset_flag <= 1'b0;
      end
      else if (running && wdgUnderflow)
        watchdog_reset_flag <= 1'b1;
    end
  end

  // ---------------- Avalon-MM slave ----------------

  // One wait state: waitrequest drops in the cycle after the request.
  assign waitrequest = (read || write) && !ack;
  assign acceptRd = read && ack;
  assign acceptWr = write && ack;
  assign ctrlWr = acceptWr && address == sim_pkg::ADDR_CTRL && !page;
  assign pllWr = acceptWr && (address == sim_pkg::ADDR_PLL ||
    (address == sim_pkg::ADDR_CTRL && page));

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ack <= 1'b0;
    else
      ack <= (read || write) && !ack;
  end

  always_comb
  begin
    ctrlView = sim_pkg::CTRL_RESET;
    ctrlView[sim_pkg::BIT_PAGE] = page;
    if (page)
      ctrlView[sim_pkg::BIT_PLL_EN] = backup_pll_enable;
    else
    begin
      ctrlView[sim_pkg::BIT_WARN_IE] = warnIe;
      ctrlView[sim_pkg::BIT_WARN_FLAG] = warnFlag;
      ctrlView[sim_pkg::BIT_LV_RF] = lvRf;
      ctrlView[sim_pkg::BIT_RSVD] = 1'b0;
      ctrlView[sim_pkg::BIT_GUARD_IE] = guardIe;
      ctrlView[sim_pkg::BIT_GUARD_DET] = guardDet;
      ctrlView[sim_pkg::BIT_WDG_RF] = watchdog_reset_flag;
    end
  end

  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (address)
      sim_pkg::ADDR_CTRL:
        next_readdata[7:0] = ctrlView;
      sim_pkg::ADDR_PLL:
        next_readdata[0] = backup_pll_enable;
      sim_pkg::ADDR_STAT:
        next_readdata[6:0] = {rstState, guardPend, warnPend,
                              backupPllRun, clockFromBackup, cpuReset};
      default:
        next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      readdata <= 32'h0000_0000;
    else if (read && !ack)
      readdata <= next_readdata;
  end

  // Control bits return to their reset values on every device reset, so a
  // wake-up by reset starts clean while a HALT exit keeps them.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      page <= 1'b0;
      warnIe <= 1'b0;
      guardIe <= 1'b0;
      backup_pll_enable <= 1'b0;
    end
    else if (!running)
    begin
      page <= 1'b0;
      warnIe <= 1'b0;
      guardIe <= 1'b0;
      backup_pll_enable <= 1'b0;
    end
    else
    begin
      if (acceptWr && address == sim_pkg::ADDR_CTRL)
        page <= writedata[sim_pkg::BIT_PAGE];
      if (ctrlWr)
      begin
        warnIe <= writedata[sim_pkg::BIT_WARN_IE];
        guardIe <= writedata[sim_pkg::BIT_GUARD_IE];
      end
      if (pllWr)
        backup_pll_enable <= (address == sim_pkg::ADDR_PLL) ? writedata[0]
                   : writedata[sim_pkg::BIT_PLL_EN];
    end
  end

  // ---------------- Supply warning ----------------

  // Without the low-voltage option the comparator is ignored entirely;
  // HALT does not stop it.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      warnFlag <= 1'b0;
      warnPrev <= 1'b0;
    end
    else
    begin
      warnFlag <= opt.lowVoltEn && supply.warnBelow;
      warnPrev <= warnFlag;
    end
  end

  // Setting the enable raises one request of its own, so an early enable
  // on a slow rise gives two and a late one gives one. Crossings during
  // reset are lost because the enable is held clear there.
  assign warnSet = opt.lowVoltEn && running && (
    (warnIe && warnFlag != warnPrev) ||
    (ctrlWr && !warnIe && writedata[sim_pkg::BIT_WARN_IE]));

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      warnPend <= 1'b0;
    else if (warnSet)
      warnPend <= 1'b1;
    else if (cpu.warnIsrAck || !opt.lowVoltEn || !running)
      warnPend <= 1'b0;
  end

  assign warnIrq = warnPend && !cpu.globalMask;

  // ---------------- Clock guard ----------------

  // The backup PLL runs at PLL_OUT_MHZ from a PLL_IN_MHZ reference; HALT
  // stops it and with it the whole guard.
  assign pllOn = (opt.pllOption || backup_pll_enable) && !cpu.haltMode;
  assign backupPllRun = pllOn;
  assign onBackup = pllOn && !oscPresent;
  assign clockFromBackup = onBackup;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      guardDet <= 1'b0;
      guardPend <= 1'b0;
      onBackupPrev <= 1'b0;
    end
    else
    begin
      onBackupPrev <= onBackup;
      if (!pllOn)
      begin
        guardDet <= 1'b0;
        guardPend <= 1'b0;
      end
      else
      begin
        if (onBackup)
          guardDet <= 1'b1;
        else if (acceptRd && address == sim_pkg::ADDR_CTRL && !page)
          guardDet <= 1'b0;
        // Only an enable already set when the switch happens counts.
        if (onBackup && !onBackupPrev && guardIe)
          guardPend <= 1'b1;
        else if (!guardDet || !guardIe)
          guardPend <= 1'b0;
      end
    end
  end

  assign guardIrq = guardPend && pllOn && !cpu.globalMask;

  // Full HALT ignores the guard; active-halt and WAIT take both.
  assign wakeUp = warnIrq && (cpu.waitMode || cpu.haltMode ||
                  cpu.activeHalt) ||
    guardIrq && (cpu.waitMode || cpu.activeHalt);

  // ---------------- Checks ----------------

  property p_lvd_hold;
    @(posedge sys_clk) disable iff (!rstn)
    opt.lowVoltEn && supply.belowRise && cpuReset |=> cpuReset;
  endproperty
  a_lvd_hold: assert property (p_lvd_hold)
    else $error("Device left reset below the rising threshold.");

  property p_pin_low;
    @(posedge sys_clk) disable iff (!rstn)
    cpuReset |-> resetPinOe && !resetPinOut;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("Reset pin not driven low during reset.");

  property p_wdg_pulse;
    @(posedge sys_clk) disable iff (!rstn)
    running && wdgUnderflow |=> resetPinOe [*8];
  endproperty
  a_wdg_pulse: assert property (p_wdg_pulse)
    else $error("Watchdog reset pulse too short.");

  property p_no_lvd;
    @(posedge sys_clk) disable iff (!rstn)
    !opt.lowVoltEn && running && !wdgUnderflow && resetPinIn
      |=> running;
  endproperty
  a_no_lvd: assert property (p_no_lvd)
    else $error("Reset without any enabled source.");

  property p_warn_off;
    @(posedge sys_clk) disable iff (!rstn)
    !opt.lowVoltEn |=> !warnFlag && !warnPend;
  endproperty
  a_warn_off: assert property (p_warn_off)
    else $error("Supply warning active without low-voltage option.");

  property p_warn_toggle;
    @(posedge sys_clk) disable iff (!rstn)
    opt.lowVoltEn && running && warnIe && $changed(warnFlag)
      |=> warnPend;
  endproperty
  a_warn_toggle: assert property (p_warn_toggle)
    else $error("Warning toggle did not raise a request.");

  property p_warn_ack;
    @(posedge sys_clk) disable iff (!rstn)
    cpu.warnIsrAck && !warnSet |=> !warnPend;
  endproperty
  a_warn_ack: assert property (p_warn_ack)
    else $error("Warning request survived service entry.");

  property p_guard_pll_off;
    @(posedge sys_clk) disable iff (!rstn)
    !pllOn |=> !guardDet && !guardIrq;
  endproperty
  a_guard_pll_off: assert property (p_guard_pll_off)
    else $error("Guard flag set while PLL disabled.");

  property p_mask;
    @(posedge sys_clk) disable iff (!rstn)
    cpu.globalMask |-> !warnIrq && !guardIrq;
  endproperty
  a_mask: assert property (p_mask)
    else $error("Interrupt raised under global mask.");

  property p_halt_guard;
    @(posedge sys_clk) disable iff (!rstn)
    cpu.haltMode && !cpu.waitMode && !cpu.activeHalt && !warnIrq
      |-> !wakeUp;
  endproperty
  a_halt_guard: assert property (p_halt_guard)
    else $error("Full HALT woken by clock guard.");

  property p_no_clock;
    @(posedge sys_clk) disable iff (!rstn)
    rstState == sim_pkg::SIM_DELAY && !oscPresent |=> cpuReset;
  endproperty
  a_no_clock: assert property (p_no_clock)
    else $error("Reset released without oscillator.");

endmodule

// ==== rtl/sim_pkg.sv ====
// Shared constants and types of the system integrity monitor.
package sim_pkg;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PLL = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;

  // Page-0 field positions of integrity_ctrl_status.
  localparam int BIT_PAGE = 7;
  localparam int BIT_WARN_IE = 6;
  localparam int BIT_WARN_FLAG = 5;
  localparam int BIT_LV_RF = 4;
  localparam int BIT_RSVD = 3;
  localparam int BIT_GUARD_IE = 2;
  localparam int BIT_GUARD_DET = 1;
  localparam int BIT_WDG_RF = 0;
  // Page-1 position of backup_pll_enable.
  localparam int BIT_PLL_EN = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMER_W = 13;
  localparam logic [12:0] RST_DELAY_SHORT_CYC = 13'h0100;
  localparam logic [12:0] RST_DELAY_LONG_CYC = 13'h1000;
  localparam int WDG_PULSE_NS = 20000;
  localparam int WDG_PULSE_CYC_I =
    (WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [12:0] WDG_PULSE_CYC = WDG_PULSE_CYC_I[12:0];
  localparam int PLL_IN_MHZ = 8;
  localparam int PLL_OUT_MHZ = 16;

  typedef enum logic [1:0]
  {
    SIM_ACTIVE = 2'b00,
    SIM_DELAY = 2'b01,
    SIM_RUN = 2'b11,
    SIM_WDG = 2'b10
  } sim_rst_state_t;

  // Nonvolatile option settings.
  typedef struct packed
  {
    logic lowVoltEn;
    logic longDelay;
    logic pllOption;
  } sim_opt_t;

  // Supply comparators, 1 means the supply is below the threshold.
  typedef struct packed
  {
    logic belowRise;
    logic belowFall;
    logic warnBelow;
  } sim_supply_t;

  // CPU side status.
  typedef struct packed
  {
    logic globalMask;
    logic warnIsrAck;
    logic waitMode;
    logic haltMode;
    logic activeHalt;
  } sim_cpu_t;

endpackage

// ==== rtl/sim_down_timer.sv ====
// Loadable down counter used for reset pulse and reset delay timing.
`timescale 1ns/1ps
module sim_down_timer #(
  parameter int W = 13
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [W-1:0] loadValue,
  input wire logic run,
  output logic done
);

  logic [W-1:0] count;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      count <= '0;
    else if (load)
      count <= loadValue;
    else if (run && count != '0)
      count <= count - 1'b1;
  end

  assign done = (count == '0);

endmodule

// ==== verif/sim_reset_partner.sv ====
// External device sharing the open-drain reset line, with the pull-up.
`timescale 1ns/1ps
module sim_reset_partner (
  input wire logic resetPinOe,
  input wire logic pullLow,
  output logic resetLine
);
  // The line idles high through the pull-up; any party may pull it low.
  assign resetLine = !(resetPinOe || pullLow);
endmodule

// ==== verif/testbench.sv ====
// Self-checking testbench of the system integrity monitor.
`timescale 1ns/1ps
module testbench;
  logic sys_clk;
  logic rstn;
  logic [3:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  sim_pkg::sim_opt_t opt;
  sim_pkg::sim_supply_t supply;
  sim_pkg::sim_cpu_t cpu;
  logic oscPresent;
  logic wdgUnderflow;
  logic resetLine;
  logic pullLow;
  logic resetPinOut;
  logic resetPinOe;
  logic cpuReset;
  logic clockFromBackup;
  logic backupPllRun;
  logic warnIrq;
  logic guardIrq;
  logic wakeUp;
  int n_fail;
  int n_checks;
  int cnt;
  logic [7:0] rd;

  sim_integrity_monitor u_sim_integrity_monitor (
    .sys_clk(sys_clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .opt(opt), .supply(supply), .cpu(cpu),
    .oscPresent(oscPresent), .wdgUnderflow(wdgUnderflow),
    .resetPinIn(resetLine), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .cpuReset(cpuReset),
    .clockFromBackup(clockFromBackup), .backupPllRun(backupPllRun),
    .warnIrq(warnIrq), .guardIrq(guardIrq), .wakeUp(wakeUp)
  );

  sim_reset_partner u_sim_reset_partner (
    .resetPinOe(resetPinOe), .pullLow(pullLow), .resetLine(resetLine)
  );

  always #(sim_pkg::CLK_PERIOD_NS / 2) sys_clk = !sys_clk;

  task automatic wrap_up();
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Each access holds its request until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] wd, output logic [7:0] d);
    logic w;
    int n;
    n = 0;
    @(posedge sys_clk);
    address <= a;
    writedata <= {24'h000000, wd};
    read <= !wr;
    write <= wr;
    do
    begin
      @(negedge sys_clk);
      w = waitrequest;
      d = readdata[7:0];
      @(posedge sys_clk);
      n++;
    end while (w !== 1'b0 && n < 50);
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50)
    begin
      n_fail++;
      $display("ERROR %0t bus access timed out", $time);
      wrap_up();
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] wd);
    logic [7:0] d;
    bus(1'b1, a, wd, d);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bus(1'b0, a, 8'h00, d);
    chk8(d, exp);
  endtask

  // Counts the cycles until the device leaves reset.
  task automatic wait_run(output int c);
    c = 0;
    while (cpuReset !== 1'b0 && c < 6000)
    begin
      @(posedge sys_clk);
      c++;
    end
    if (c >= 6000)
    begin
      n_fail++;
      $display("ERROR %0t device stuck in reset", $time);
      wrap_up();
    end
    wait_cyc(1);
  endtask

  task automatic ack_warn();
    cpu.warnIsrAck <= 1'b1;
    @(posedge sys_clk);
    cpu.warnIsrAck <= 1'b0;
    wait_cyc(2);
  endtask

  initial
  begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    opt = '{lowVoltEn: 1'b1, longDelay: 1'b0, pllOption: 1'b0};
    supply = '{belowRise: 1'b0, belowFall: 1'b0, warnBelow: 1'b0};
    cpu = '0;
    oscPresent = 1'b1;
    wdgUnderflow = 1'b0;
    pullLow = 1'b0;
    n_fail = 0;
    n_checks = 0;
    wait_cyc(3);
    rstn <= 1'b1;
    wait_run(cnt);
    chk1(cnt >= 256, 1'b1);
    rd_chk(sim_pkg::ADDR_CTRL, sim_pkg::CTRL_RESET);
    // Early enable raises one request before any threshold crossing.
    bus_wr(sim_pkg::ADDR_CTRL, 8'h48);
    rd_chk(sim_pkg::ADDR_CTRL, 8'h40);
    chk1(warnIrq, 1'b1);
    ack_warn();
    chk1(warnIrq, 1'b0);
    supply.warnBelow <= 1'b1;
    wait_cyc(4);
    chk1(warnIrq, 1'b1);
    rd_chk(sim_pkg::ADDR_CTRL, 8'h60);
    cpu.globalMask <= 1'b1;
    wait_cyc(2);
    chk1(warnIrq, 1'b0);
    cpu.globalMask <= 1'b0;
    ack_warn();
    // Without the low-voltage option the warning flag reads inactive.
    opt.lowVoltEn <= 1'b0;
    wait_cyc(4);
    rd_chk(sim_pkg::ADDR_CTRL, 8'h40);
    supply.warnBelow <= 1'b0;
    opt.lowVoltEn <= 1'b1;
    wait_cyc(3);
    ack_warn();
    rd_chk(4'hc, 8'h00);
    // Watchdog underflow drives the pin for at least the minimum width.
    wdgUnderflow <= 1'b1;
    @(posedge sys_clk);
    wdgUnderflow <= 1'b0;
    wait_cyc(1);
    cnt = 0;
    while (resetPinOe === 1'b1 && cnt < 6000)
    begin
      @(posedge sys_clk);
      cnt++;
    end
    chk1(cnt >= int'(sim_pkg::WDG_PULSE_CYC), 1'b1);
    wait_run(cnt);
    rd_chk(sim_pkg::ADDR_CTRL, 8'h01);
    bus_wr(sim_pkg::ADDR_CTRL, 8'h00);
    rd_chk(sim_pkg::ADDR_CTRL, 8'h00);
    // Hysteresis: once in reset, release needs the rising threshold.
    supply.belowFall <= 1'b1;
    supply.belowRise <= 1'b1;
    wait_cyc(3);
    chk1(resetPinOe, 1'b1);
    chk1(resetLine, 1'b0);
    supply.belowFall <= 1'b0;
    wait_cyc(20);
    chk1(cpuReset, 1'b1);
    supply.belowRise <= 1'b0;
    wait_run(cnt);
    rd_chk(sim_pkg::ADDR_CTRL, 8'h10);
    bus_wr(sim_pkg::ADDR_CTRL, 8'h00);
    // The shared line pulled low by the partner resets the device.
    pullLow <= 1'b1;
    wait_cyc(3);
    chk1(cpuReset, 1'b1);
    pullLow <= 1'b0;
    wait_run(cnt);
    opt.lowVoltEn <= 1'b0;
    supply.belowFall <= 1'b1;
    supply.belowRise <= 1'b1;
    wait_cyc(10);
    chk1(cpuReset, 1'b0);
    supply <= '0;
    opt.lowVoltEn <= 1'b1;
    // Clock guard with the backup PLL enabled by software.
    bus_wr(sim_pkg::ADDR_PLL, 8'h01);
    bus_wr(sim_pkg::ADDR_CTRL, 8'h04);
    wait_cyc(2);
    chk1(backupPllRun, 1'b1);
    oscPresent <= 1'b0;
    wait_cyc(3);
    chk1(clockFromBackup, 1'b1);
    chk1(guardIrq, 1'b1);
    rd_chk(sim_pkg::ADDR_CTRL, 8'h06);
    oscPresent <= 1'b1;
    wait_cyc(2);
    rd_chk(sim_pkg::ADDR_CTRL, 8'h06);
    rd_chk(sim_pkg::ADDR_CTRL, 8'h04);
    cpu.haltMode <= 1'b1;
    wait_cyc(2);
    chk1(backupPllRun, 1'b0);
    // Full HALT: the supply warning still wakes the device.
    bus_wr(sim_pkg::ADDR_CTRL, 8'h44);
    wait_cyc(2);
    chk1(wakeUp, 1'b1);
    ack_warn();
    chk1(wakeUp, 1'b0);
    // Active-halt: a lost oscillator raises the guard and wakes the device.
    cpu.haltMode <= 1'b0;
    cpu.activeHalt <= 1'b1;
    oscPresent <= 1'b0;
    wait_cyc(3);
    chk1(wakeUp, 1'b1);
    rd_chk(sim_pkg::ADDR_STAT, 8'h76);
    cpu.activeHalt <= 1'b0;
    cpu.waitMode <= 1'b1;
    wait_cyc(2);
    chk1(wakeUp, 1'b1);
    oscPresent <= 1'b1;
    wait_cyc(2);
    rd_chk(sim_pkg::ADDR_CTRL, 8'h46);
    wait_cyc(2);
    chk1(wakeUp, 1'b0);
    cpu.waitMode <= 1'b0;
    // With the PLL off the guard enable has no effect.
    bus_wr(sim_pkg::ADDR_PLL, 8'h00);
    oscPresent <= 1'b0;
    wait_cyc(3);
    chk1(guardIrq, 1'b0);
    chk1(clockFromBackup, 1'b0);
    rd_chk(sim_pkg::ADDR_CTRL, 8'h44);
    oscPresent <= 1'b1;
    wait_cyc(2);
    wrap_up();
  end
endmodule
